// ==== hw/pdl_core.sv ====
// synthesizer divider, lock qualification, calibration and register file
`timescale 1ns/1ns
`include "pdl_defines.svh"
module pdl_core (
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        wr_en_i,
    input  wire logic [4:0]  wr_addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        ref_edge_i,
    input  wire logic        vco_edge_i,
    input  wire logic        phase_ok_i,
    output logic [31:0]      rd_data_o,
    output logic [11:0]      pump_current_ua_o,
    output logic             ref_pulse_o,
    output logic             fb_pulse_o,
    output logic             cal_busy_o,
    output logic             sync_o,
    output logic             digital_lock_flag_o,
    output logic [2:0]       ref_freq_range_code_o
);
    // ****************************************
    // register storage
    // ****************************************
    logic [31:0] r12_q;
    logic [31:0] r26_q;
    logic [31:0] r28_q;
    logic [31:0] r29_q;
    logic [31:0] r30_q;
    logic [31:0] r31_q;
    logic        write_protect_bit;
    logic        wr_ok;
    logic        cal_start;

    assign write_protect_bit = r31_q[`PDL_WPROT_BIT];
    assign wr_ok     = wr_en_i && (!write_protect_bit || wr_addr_i == `PDL_ADDR_R31);
    assign cal_start = wr_ok && wr_addr_i == `PDL_ADDR_R30;

    // register writes
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            r12_q <= `PDL_RST_WORD;
            r26_q <= `PDL_RST_WORD;
            r28_q <= `PDL_RST_WORD;
            r29_q <= `PDL_RST_WORD;
            r30_q <= `PDL_RST_WORD;
            r31_q <= `PDL_RST_WORD;
        end else if (wr_ok) begin
            case (wr_addr_i)
                `PDL_ADDR_R12: r12_q <= wr_data_i;
                `PDL_ADDR_R26: r26_q <= wr_data_i;
                `PDL_ADDR_R28: r28_q <= wr_data_i;
                `PDL_ADDR_R29: r29_q <= wr_data_i;
                `PDL_ADDR_R30: r30_q <= wr_data_i;
                `PDL_ADDR_R31: r31_q <= wr_data_i;
                default: ;
            endcase
        end
    end

    // ****************************************
    // readback
    // ****************************************
    logic [4:0] rb_addr;
    assign rb_addr = r31_q[`PDL_RBADDR_MSB:`PDL_RBADDR_LSB];

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            rd_data_o <= `PDL_RST_WORD;
        end else begin
            case (rb_addr)
                `PDL_ADDR_R12: rd_data_o <= r12_q;
                `PDL_ADDR_R26: rd_data_o <= r26_q;
                `PDL_ADDR_R28: rd_data_o <= r28_q;
                `PDL_ADDR_R29: rd_data_o <= r29_q;
                `PDL_ADDR_R30: rd_data_o <= r30_q;
                default:       rd_data_o <= `PDL_RST_WORD;
            endcase
        end
    end

    // ****************************************
    // pump current and range code
    // ****************************************
    logic [1:0] pump_current_code;
    assign pump_current_code = r26_q[`PDL_CP_MSB:`PDL_CP_LSB];

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            pump_current_ua_o <= `PDL_CP_UA_0;
        end else begin
            case (pump_current_code)
                2'd0:    pump_current_ua_o <= `PDL_CP_UA_0;
                2'd1:    pump_current_ua_o <= `PDL_CP_UA_1;
                2'd2:    pump_current_ua_o <= `PDL_CP_UA_2;
                default: pump_current_ua_o <= `PDL_CP_UA_3;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ref_freq_range_code_o <= 3'd0;
        end else begin
            ref_freq_range_code_o <= r29_q[`PDL_RANGE_MSB:`PDL_RANGE_LSB];
        end
    end

    // ****************************************
    // synchronise the edge and window inputs
    // ****************************************
    logic [2:0] ref_s_q;
    logic [2:0] vco_s_q;
    logic [2:0] ok_s_q;
    logic       ref_tick;
    logic       vco_tick;

    // three stages; edges act once stages two and three agree, the window uses stage three alone
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ref_s_q <= 3'd0;
            vco_s_q <= 3'd0;
            ok_s_q  <= 3'd0;
        end else begin
            ref_s_q <= {ref_s_q[1:0], ref_edge_i};
            vco_s_q <= {vco_s_q[1:0], vco_edge_i};
            ok_s_q  <= {ok_s_q[1:0], phase_ok_i};
        end
    end

    logic ref_lvl_q;
    logic vco_lvl_q;
    // filtered levels, rising edge gives one tick
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ref_lvl_q <= 1'b0;
            vco_lvl_q <= 1'b0;
        end else begin
            if (ref_s_q[1] == ref_s_q[2]) ref_lvl_q <= ref_s_q[2];
            if (vco_s_q[1] == vco_s_q[2]) vco_lvl_q <= vco_s_q[2];
        end
    end
    assign ref_tick = (ref_s_q[1] == ref_s_q[2]) && ref_s_q[2] && !ref_lvl_q;
    assign vco_tick = (vco_s_q[1] == vco_s_q[2]) && vco_s_q[2] && !vco_lvl_q;

    // ****************************************
    // dividers
    // ****************************************
    logic [3:0]  pre_div;
    logic [2:0]  pre_code;
    logic [17:0] n_sel;
    logic        pre_pulse;

    assign pre_code = r30_q[`PDL_PRE_MSB:`PDL_PRE_LSB];
    always_comb begin
        case (pre_code)
            3'd0:    pre_div = `PDL_PRE_CODE0_DIV;
            3'd1:    pre_div = `PDL_PRE_MIN_DIV;
            3'd2:    pre_div = `PDL_PRE_MIN_DIV;
            default: pre_div = {1'b0, pre_code};
        endcase
    end

    assign n_sel = cal_busy_o ? r29_q[`PDL_NCAL_MSB:`PDL_NCAL_LSB]
                              : r30_q[`PDL_NDIV_MSB:`PDL_NDIV_LSB];

    pdl_divider #(.WIDTH(12)) u_ref_div (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .tick_i     (ref_tick),
        .divide_i   (r28_q[`PDL_RDIV_MSB:`PDL_RDIV_LSB]),
        .pulse_o    (ref_pulse_o)
    );

    pdl_divider #(.WIDTH(4)) u_pre_div (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .tick_i     (vco_tick),
        .divide_i   (pre_div),
        .pulse_o    (pre_pulse)
    );

    pdl_divider #(.WIDTH(18)) u_fb_div (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .tick_i     (pre_pulse),
        .divide_i   (n_sel),
        .pulse_o    (fb_pulse_o)
    );

    // ****************************************
    // lock qualification
    // ****************************************
    logic [13:0] qual_cnt_q;
    logic [13:0] qual_target;
    logic        ok_now;

    assign qual_target = r26_q[`PDL_QCNT_MSB:`PDL_QCNT_LSB];
    assign ok_now      = ok_s_q[2];

    // miss restarts count and drops lock
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            qual_cnt_q          <= 14'h0000;
            digital_lock_flag_o <= 1'b0;
        end else if (ref_pulse_o) begin
            if (!ok_now || qual_target == 14'h0000) begin
                qual_cnt_q          <= 14'h0000;
                digital_lock_flag_o <= 1'b0;
            end else if (qual_cnt_q + 14'h0001 >= qual_target) begin
                qual_cnt_q          <= qual_target;
                digital_lock_flag_o <= 1'b1;
            end else begin
                qual_cnt_q <= qual_cnt_q + 14'h0001;
            end
        end
    end

    // ****************************************
    // calibration sequencer
    // ****************************************
    pdl_pkg::pdl_cal_state_t cal_state_q;
    logic [15:0]             cal_cnt_q;

    // restart on every accepted write to register 30
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            cal_state_q <= pdl_pkg::PDL_CAL_IDLE;
            cal_cnt_q   <= 16'h0000;
        end else if (cal_start) begin
            cal_state_q <= pdl_pkg::PDL_CAL_RUN;
            cal_cnt_q   <= 16'h0000;
        end else begin
            case (cal_state_q)
                pdl_pkg::PDL_CAL_RUN: begin
                    if (ref_tick) begin
                        if (cal_cnt_q + 16'h0001 >= `PDL_CAL_CYCLES) begin
                            cal_state_q <= pdl_pkg::PDL_CAL_DONE;
                        end else begin
                            cal_cnt_q <= cal_cnt_q + 16'h0001;
                        end
                    end
                end
                pdl_pkg::PDL_CAL_DONE: cal_state_q <= pdl_pkg::PDL_CAL_IDLE;
                default:               cal_state_q <= pdl_pkg::PDL_CAL_IDLE;
            endcase
        end
    end
    assign cal_busy_o = (cal_state_q == pdl_pkg::PDL_CAL_RUN);

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            sync_o <= 1'b0;
        end else begin
            sync_o <= cal_start || cal_busy_o ||
                      (r12_q[`PDL_SYNC_LOCK_BIT] && !digital_lock_flag_o);
        end
    end
endmodule

// ==== hw/pdl_defines.svh ====
// constants for the synthesizer divider, lock and calibration block
`ifndef PDL_DEFINES_SVH
`define PDL_DEFINES_SVH
// ****************************************
// register addresses and fields
// ****************************************
`define PDL_ADDR_R12        5'd12
`define PDL_ADDR_R26        5'd26
`define PDL_ADDR_R28        5'd28
`define PDL_ADDR_R29        5'd29
`define PDL_ADDR_R30        5'd30
`define PDL_ADDR_R31        5'd31
`define PDL_SYNC_LOCK_BIT   23
`define PDL_CP_MSB          27
`define PDL_CP_LSB          26
`define PDL_QCNT_MSB        19
`define PDL_QCNT_LSB        6
`define PDL_RDIV_MSB        31
`define PDL_RDIV_LSB        20
`define PDL_RANGE_MSB       26
`define PDL_RANGE_LSB       24
`define PDL_NCAL_MSB        22
`define PDL_NCAL_LSB        5
`define PDL_PRE_MSB         26
`define PDL_PRE_LSB         24
`define PDL_NDIV_MSB        22
`define PDL_NDIV_LSB        5
`define PDL_RBADDR_MSB      20
`define PDL_RBADDR_LSB      16
`define PDL_WPROT_BIT       5
// ****************************************
// reset values and timing
// ****************************************
`define PDL_RST_WORD        32'h0000_0000
`define PDL_CP_UA_0         12'h064
`define PDL_CP_UA_1         12'h190
`define PDL_CP_UA_2         12'h640
`define PDL_CP_UA_3         12'hC80
`define PDL_PRE_CODE0_DIV   4'h8
`define PDL_PRE_MIN_DIV     4'h2
// calibration run time in reference cycles
`define PDL_CAL_CYCLES      16'h0400
`endif

// ==== hw/pdl_pkg.sv ====
// types for the synthesizer divider, lock and calibration block
package pdl_pkg;
    typedef enum logic [1:0] {
        PDL_CAL_IDLE,
        PDL_CAL_RUN,
        PDL_CAL_DONE
    } pdl_cal_state_t;
endpackage

// ==== hw/pdl_divider.sv ====
// programmable integer divider producing a one-cycle terminal pulse
`timescale 1ns/1ns
module pdl_divider #(
    parameter int WIDTH = 18
) (
    input  wire logic             core_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             tick_i,
    input  wire logic [WIDTH-1:0] divide_i,
    output logic                  pulse_o
);
    logic [WIDTH-1:0] count_q;

    // count ticks, pulse on the last of each period
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            count_q <= '0;
            pulse_o <= 1'b0;
        end else begin
            pulse_o <= 1'b0;
            if (tick_i) begin
                if (count_q + WIDTH'(1) >= divide_i) begin
                    count_q <= '0;
                    pulse_o <= 1'b1;
                end else begin
                    count_q <= count_q + WIDTH'(1);
                end
            end
        end
    end
endmodule

// ==== verification/pdl_monitor.sv ====
// concurrent checks on the divider, lock and calibration block ports
`timescale 1ns/1ns
module pdl_monitor (
    input wire logic        core_clk_i,
    input wire logic        rstn_i,
    input wire logic        wr_en_i,
    input wire logic [4:0]  wr_addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic        ref_edge_i,
    input wire logic        vco_edge_i,
    input wire logic        phase_ok_i,
    input wire logic [31:0] rd_data_o,
    input wire logic [11:0] pump_current_ua_o,
    input wire logic        ref_pulse_o,
    input wire logic        fb_pulse_o,
    input wire logic        cal_busy_o,
    input wire logic        sync_o,
    input wire logic        digital_lock_flag_o,
    input wire logic [2:0]  ref_freq_range_code_o
);
    logic        prot_q;
    logic        hold_q;
    logic        acc;
    logic [11:0] ua_q;
    logic [2:0]  rng_q;
    assign acc = wr_en_i && (!prot_q || wr_addr_i == 5'h1f);
    // ****************************************
    // mirrors of write protect and fields
    // ****************************************
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            prot_q <= 1'b0;
            hold_q <= 1'b0;
        end else if (wr_en_i && wr_addr_i == 5'h1f) begin
            prot_q <= wr_data_i[5];
        end else if (acc && wr_addr_i == 5'h0c) begin
            hold_q <= wr_data_i[23];
        end
    end
    // expected pump current and range copy
    always_ff @(posedge core_clk_i) begin
        if (acc && wr_addr_i == 5'h1a) begin
            ua_q <= wr_data_i[27] ? (wr_data_i[26] ? 12'hc80 : 12'h640)
                                  : (wr_data_i[26] ? 12'h190 : 12'h064);
        end
        if (acc && wr_addr_i == 5'h1d) begin
            rng_q <= wr_data_i[26:24];
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_cal_end;
        $fell(cal_busy_o) && !hold_q;
    endsequence
    sequence s_sync_drop;
        sync_o ##1 !sync_o;
    endsequence
    a_pump_code: assert property (
        acc && wr_addr_i == 5'h1a ##1 !(acc && wr_addr_i == 5'h1a) |=> pump_current_ua_o == ua_q)
        else $error("pump current does not follow its code");
    a_range_copy: assert property (
        acc && wr_addr_i == 5'h1d ##1 !(acc && wr_addr_i == 5'h1d) |=> ref_freq_range_code_o == rng_q)
        else $error("range code copy wrong");
    a_cal_start: assert property (acc && wr_addr_i == 5'h1e |=> cal_busy_o && sync_o)
        else $error("calibration or sync did not start");
    a_sync_cover: assert property (cal_busy_o |-> sync_o)
        else $error("sync low during calibration");
    a_sync_fall: assert property (s_cal_end |-> s_sync_drop)
        else $error("sync did not end one cycle after calibration");
    a_sync_hold: assert property (
        $fell(cal_busy_o) && hold_q && !digital_lock_flag_o |-> sync_o)
        else $error("sync released before lock");
    a_lock_drop: assert property (
        ref_pulse_o && !phase_ok_i && !$past(phase_ok_i, 2) && !$past(phase_ok_i, 4)
        |=> !digital_lock_flag_o)
        else $error("lock kept after bad compare");
    a_lock_rise: assert property ($rose(digital_lock_flag_o) |-> $past(ref_pulse_o))
        else $error("lock rose without a compare");
    a_ref_gap: assert property (ref_pulse_o |=> !ref_pulse_o [*3])
        else $error("reference pulses too close");
    a_fb_gap: assert property (fb_pulse_o |=> !fb_pulse_o [*4])
        else $error("feedback pulses too close");
endmodule
bind pdl_core pdl_monitor u_pdl_monitor (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i), .ref_edge_i(ref_edge_i), .vco_edge_i(vco_edge_i),
    .phase_ok_i(phase_ok_i), .rd_data_o(rd_data_o), .pump_current_ua_o(pump_current_ua_o),
    .ref_pulse_o(ref_pulse_o), .fb_pulse_o(fb_pulse_o), .cal_busy_o(cal_busy_o),
    .sync_o(sync_o), .digital_lock_flag_o(digital_lock_flag_o),
    .ref_freq_range_code_o(ref_freq_range_code_o)
);

// ==== verification/pdl_host_model.sv ====
// host model that writes configuration registers, one word per strobe
`timescale 1ns/1ns
module pdl_host_model (
    input  wire logic   core_clk_i,
    output logic        wr_en_o,
    output logic [4:0]  wr_addr_o,
    output logic [31:0] wr_data_o
);
    initial begin
        wr_en_o = 1'b0;
        wr_addr_o = 5'h00;
        wr_data_o = 32'h0000_0000;
    end
    // one strobe for a valid word, then the bus shows inverted values; invalid words are not sent
    task automatic write(input logic [4:0] addr, input logic [31:0] data);
        if ((addr == 5'h1c && data[31:20] == 12'h000) || (addr == 5'h1e && data[22:5] == 18'h0)
            || (addr == 5'h1d && data[26:24] == 3'h3)) begin
            $display("host model: invalid word for register %0d not sent", addr);
        end else begin
            @(negedge core_clk_i);
            wr_en_o <= 1'b1;
            wr_addr_o <= addr;
            wr_data_o <= data;
            @(negedge core_clk_i);
            wr_en_o <= 1'b0;
            wr_addr_o <= ~addr;
            wr_data_o <= ~data;
        end
    endtask
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the divider, lock and calibration block
`timescale 1ns/1ns
module tb_top;
    logic        core_clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        ref_edge_i = 1'b0;
    logic        vco_edge_i = 1'b0;
    logic        phase_ok_i = 1'b0;
    logic        wr_en, ref_pulse, fb_pulse, cal_busy, sync, lock;
    logic [4:0]  wr_addr;
    logic [31:0] wr_data, rd_data;
    logic [11:0] pump_ua;
    logic [2:0]  range;
    logic [11:0] ua [4] = '{12'h064, 12'h190, 12'h640, 12'hc80};
    int          err_count = 0;
    int          checked = 0;
    int          cyc = 0;
    int          n;
    int          pdiv;
    always #10 core_clk_i = ~core_clk_i;
    // reference every 8 cycles, oscillator every 6 cycles
    always @(negedge core_clk_i) begin
        cyc <= cyc + 1;
        ref_edge_i <= (cyc % 8) < 4;
        vco_edge_i <= (cyc % 6) < 3;
    end
    pdl_host_model u_pdl_host_model (.core_clk_i(core_clk_i), .wr_en_o(wr_en),
        .wr_addr_o(wr_addr), .wr_data_o(wr_data));
    pdl_core u_pdl_core (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .wr_en_i(wr_en),
        .wr_addr_i(wr_addr), .wr_data_i(wr_data), .ref_edge_i(ref_edge_i),
        .vco_edge_i(vco_edge_i), .phase_ok_i(phase_ok_i), .rd_data_o(rd_data),
        .pump_current_ua_o(pump_ua), .ref_pulse_o(ref_pulse), .fb_pulse_o(fb_pulse),
        .cal_busy_o(cal_busy), .sync_o(sync), .digital_lock_flag_o(lock),
        .ref_freq_range_code_o(range));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic near(input string name, input int e, input int m);
        chk(name, 32'(e), 32'((m >= e - 1 && m <= e + 1) ? e : m));
    endtask
    task automatic w(input logic [4:0] a, input logic [31:0] d);
        u_pdl_host_model.write(a, d);
    endtask
    task automatic count(input bit fb, input int cycles, output int m);
        m = 0;
        repeat (cycles) begin
            @(posedge core_clk_i);
            #1;
            if (fb ? fb_pulse : ref_pulse) m++;
        end
    endtask
    task automatic wait_ref();
        int i;
        @(negedge core_clk_i);
        for (i = 0; i < 200 && ref_pulse !== 1'b1; i++) @(negedge core_clk_i);
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 12000 && cal_busy !== 1'b0; i++) @(negedge core_clk_i);
        chk("cal idle", 32'h0, {31'h0, cal_busy});
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge core_clk_i);
        err_count++;
        $display("[FAIL] watchdog expected end seen timeout");
        stop_test();
    end
    initial begin
        repeat (4) @(negedge core_clk_i);
        rstn_i = 1'b1;
        @(negedge core_clk_i);
        chk("pump reset", 32'h0000_0064, {20'h0, pump_ua});
        for (int c = 0; c < 4; c++) begin
            w(5'h1a, {4'h0, c[1:0], 26'h000_0080});
            repeat (3) @(negedge core_clk_i);
            chk("pump current", {20'h0, ua[c]}, {20'h0, pump_ua});
        end
        w(5'h1f, 32'h001a_0000);
        repeat (3) @(negedge core_clk_i);
        chk("readback", 32'h0c00_0080, rd_data);
        $display("test pump and readback finished");
        w(5'h1c, 32'h0040_0000);
        count(1'b0, 640, n);
        near("reference pulses", 20, n);
        wait_ref();
        phase_ok_i = 1'b1;
        wait_ref();
        repeat (2) @(negedge core_clk_i);
        chk("lock early", 32'h0, {31'h0, lock});
        wait_ref();
        repeat (2) @(negedge core_clk_i);
        chk("lock", 32'h1, {31'h0, lock});
        phase_ok_i = 1'b0;
        wait_ref();
        repeat (2) @(negedge core_clk_i);
        chk("lock drop", 32'h0, {31'h0, lock});
        $display("test divider and lock finished");
        w(5'h1d, 32'h0400_0020);
        repeat (3) @(negedge core_clk_i);
        chk("range code", 32'h4, {29'h0, range});
        for (int p = 0; p < 8; p++) begin
            w(5'h1e, {5'h0, p[2:0], 1'h0, 18'h3, 5'h0});
            repeat (4) @(negedge core_clk_i);
            chk("cal busy", 32'h1, {31'h0, cal_busy});
            chk("sync", 32'h1, {31'h0, sync});
            pdiv = (p == 0) ? 8 : (p < 3) ? 2 : p;
            count(1'b1, 336, n);
            near("feedback pulses in cal", 336 / (6 * pdiv), n);
        end
        w(5'h0c, 32'h0080_0000);
        wait_idle();
        chk("sync held", 32'h1, {31'h0, sync});
        count(1'b1, 504, n);
        near("feedback pulses", 4, n);
        phase_ok_i = 1'b1;
        repeat (3) wait_ref();
        repeat (2) @(negedge core_clk_i);
        chk("sync after lock", 32'h0, {31'h0, sync});
        $display("test calibration finished");
        w(5'h1f, 32'h001d_0020);
        w(5'h1d, 32'h0200_0020);
        w(5'h1e, 32'h0300_0060);
        repeat (3) @(negedge core_clk_i);
        chk("cal blocked", 32'h0, {31'h0, cal_busy});
        chk("range kept", 32'h4, {29'h0, range});
        chk("readback locked", 32'h0400_0020, rd_data);
        w(5'h1f, 32'h001d_0000);
        w(5'h1d, 32'h0200_0020);
        repeat (3) @(negedge core_clk_i);
        chk("range unlocked", 32'h2, {29'h0, range});
        chk("readback unlocked", 32'h0200_0020, rd_data);
        $display("test write protect finished");
        stop_test();
    end
endmodule
